// ### cffc_apply.sv
`timescale 1ns/1ps
`default_nettype none
module cffc_apply
    import cffc_pkg::*;
(
    input wire logic ref_clk_i, // Pixel clock
    input wire logic arst_n_i, // Async reset, low
    input wire cffc_pix_t pix_i, // Pixel with column terms
    input wire cffc_coef_t coef_i, // Column coefficients
    input wire logic en_i, // Correction on
    output cffc_pix_t pix_o // Corrected pixel
);
    typedef struct packed {
        cffc_pix_t a_pix;
        logic a_en;
        logic signed [PIX_W+1:0] a_sum;
        logic [GAIN_W-1:0] a_gain;
        cffc_pix_t b_pix;
    } cffc_ap_st_t;

    cffc_ap_st_t r, n;
    logic signed [PIX_W+GAIN_W+2:0] prod;
    // Every product bit above the fraction is kept, so large gains clamp
    logic signed [PIX_W+GAIN_W+2-GAIN_FRAC:0] scaled;

    // Add offset, then scale by gain and clamp to pixel range
    always_comb begin
        n = r;
        n.a_pix = pix_i;
        n.a_en = en_i;
        n.a_sum = $signed({2'b00, pix_i.data})
            + $signed({{2{coef_i.offs[15]}}, coef_i.offs});
        n.a_gain = coef_i.gain;
        prod = r.a_sum * $signed({1'b0, r.a_gain});
        scaled = prod[PIX_W+GAIN_W+2:GAIN_FRAC];
        n.b_pix = r.a_pix;
        if (r.a_en) begin
            if (scaled < 0) begin
                n.b_pix.data = '0;
            end else if (scaled > $signed({3'b000, {PIX_W{1'b1}}})) begin
                n.b_pix.data = '1;
            end else begin
                n.b_pix.data = scaled[PIX_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pix_o = r.b_pix;

    AST_BYPASS_DATA: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (pix_i.valid && !en_i) |-> ##2 (pix_o.data == $past(pix_i.data, 2)))
        else $error("bypassed pixel altered");
    AST_BEAT_KEPT: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        pix_i.valid |-> ##2 (pix_o.valid
            && pix_o.line_start == $past(pix_i.line_start, 2)))
        else $error("pixel beat lost or moved");
endmodule // cffc_apply
`default_nettype wire

// ### cffc_pix_src.sv
`timescale 1ns/1ps
`default_nettype none
module cffc_pix_src
    import cffc_pkg::*;
(
    input wire logic ref_clk_i, // Pixel clock
    output var cffc_pix_t pix_o // Sensor stream
);
    // Quiet stream until the bench asks for a line
    initial pix_o = '0;

    // One line of eight beats; gap idles between beats model a slow sensor.
    // Idle beats carry inverted data, so a stale value never looks valid.
    task automatic send_line(input logic [PIX_W-1:0] base, input int gap);
        for (int c = 0; c < 8; c++) begin
            @(posedge ref_clk_i);
            pix_o.valid <= 1'b1;
            pix_o.frame_start <= (c == 0);
            pix_o.line_start <= (c == 0);
            pix_o.data <= base + PIX_W'(c);
            repeat (gap) begin
                @(posedge ref_clk_i);
                pix_o <= '{1'b0, 1'b0, 1'b0, ~pix_o.data};
            end
        end
        @(posedge ref_clk_i);
        pix_o <= '{1'b0, 1'b0, 1'b0, ~pix_o.data};
    endtask
endmodule // cffc_pix_src
`default_nettype wire

// ### cffc_pkg.sv
// Overview of operation
// - With enable clear pixels pass untouched, with it set they are corrected outside calibration mode and table walks.
// - The mode selector holds exactly factory, user or calibration.
// - Column index, gain and offset are reachable only in calibration mode.
// - Leaving calibration loads the new mode's table into the active path.
// - An integer column index picks the column whose user terms are accessed.
// - The selected column's user delta gain can be read and written.
// - The selected column's user 16-bit delta offset can be read and written.
// - The reload command refills the user table from the saved copy.
// - With nothing saved, the reload command loads no-correction defaults.
// - The store command copies the user table over the saved copy.
// - Output is column gain times the sum of pixel and column offset.
// - Calibration mode forces correction off and locks the enable.
// - User mode uses one set for all gains, factory varies with gain level.
// - An offset write off the reported step is refused and flagged.
package cffc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COL_W = 8;
    localparam int NUM_COLS = 256;
    localparam int PIX_W = 16;
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 12;
    localparam int LVL_W = 2;
    localparam int STEP_LOG = 5;
    localparam int PIPE_LAT = 3;
    localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h1000;
    localparam logic [15:0] OFFS_STEP = 16'h0020;
    localparam logic [COL_W-1:0] COL_LAST = 8'hFF;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_COL = 8'h10;
    localparam logic [ADDR_W-1:0] REG_GAIN = 8'h14;
    localparam logic [ADDR_W-1:0] REG_OFFS = 8'h18;
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_STEP = 8'h20;
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CMD_RELOAD_BIT = 0;
    localparam int CMD_STORE_BIT = 1;
    localparam int IRQ_W = 4;
    localparam int IRQ_REFUSED = 0;
    localparam int IRQ_OFFS_ERR = 1;
    localparam int IRQ_CMD_DONE = 2;
    localparam int IRQ_LOAD_DONE = 3;

    typedef enum logic [1:0] {
        MODE_FACTORY = 2'h0,
        MODE_USER = 2'h1,
        MODE_CALIB = 2'h2
    } cffc_mode_t;

    typedef struct packed {
        logic valid;
        logic frame_start;
        logic line_start;
        logic [PIX_W-1:0] data;
    } cffc_pix_t;

    typedef struct packed {
        logic [GAIN_W-1:0] gain;
        logic [15:0] offs;
    } cffc_coef_t;

    localparam cffc_coef_t COEF_NONE = '{gain: GAIN_UNITY, offs: 16'h0000};
    // Factory set per camera gain level, column independent
    localparam cffc_coef_t FACT_COEF [4] = '{
        '{gain: 16'h1000, offs: 16'h0000},
        '{gain: 16'h1040, offs: 16'hFFE0},
        '{gain: 16'h1080, offs: 16'hFFC0},
        '{gain: 16'h10C0, offs: 16'hFFA0}
    };
endpackage

// ### cffc_top.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cffc_top
    import cffc_pkg::*;
(
    input wire logic ref_clk_i, // Pixel clock
    input wire logic arst_n_i, // Async reset, low
    input wire logic [ADDR_W-1:0] addr_i, // Register address
    input wire logic [DATA_W-1:0] wdata_i, // Write data
    input wire logic we_i, // Write strobe
    input wire logic re_i, // Read strobe
    output logic [DATA_W-1:0] rdata_o, // Read data, cycle after
    output logic irq_o, // Level interrupt
    input wire logic [LVL_W-1:0] cam_gain_level_i, // Camera gain level
    input wire cffc_pix_t pix_i, // Pixel stream in
    output cffc_pix_t pix_o // Corrected stream out
);
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_LOAD,
        SEQ_RELOAD,
        SEQ_STORE
    } cffc_seq_t;

    typedef struct packed {
        logic enable;
        cffc_mode_t mode;
        logic [COL_W-1:0] col_idx;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        cffc_seq_t seq;
        logic [COL_W-1:0] cnt;
        logic nv_valid;
        logic act_factory;
        logic pend_valid;
        logic [ADDR_W-1:0] pend_addr;
        logic [15:0] pend_data;
        logic [COL_W-1:0] pix_col;
        cffc_pix_t s1_pix;
        cffc_coef_t s1_coef;
        logic s1_en;
    } cffc_st_t;

    cffc_st_t r, n;
    // Tables: user edit copy, saved copy, active copy used by the pixels
    cffc_coef_t user_tbl [NUM_COLS];
    cffc_coef_t nv_tbl [NUM_COLS];
    cffc_coef_t act_tbl [NUM_COLS];

    logic usr_we, nv_we, act_we;
    logic [COL_W-1:0] usr_wa, cur_col;
    cffc_coef_t usr_wd, user_at_idx;
    logic [IRQ_W-1:0] ev;
    logic busy, calib, hold, coef_acc, acc_v;
    logic [ADDR_W-1:0] acc_addr;
    logic [15:0] acc_data;
    cffc_mode_t new_mode;
    logic corr_en;

    assign busy = (r.seq != SEQ_IDLE);
    assign calib = (r.mode == MODE_CALIB);
    assign hold = busy || r.pend_valid;
    assign user_at_idx = user_tbl[r.col_idx];
    assign new_mode = cffc_mode_t'(wdata_i[CTRL_MODE_LSB +: 2]);
    assign coef_acc = (addr_i == REG_COL) || (addr_i == REG_GAIN)
        || (addr_i == REG_OFFS);
    // Calibration and table loads both keep the path uncorrected
    assign corr_en = r.enable && !calib && !busy;
    assign cur_col = pix_i.line_start ? '0 : r.pix_col;

    // Register access, sequencer and first pixel stage
    always_comb begin
        n = r;
        ev = '0;
        usr_we = 1'b0;
        usr_wa = r.col_idx;
        usr_wd = user_at_idx;
        nv_we = 1'b0;
        act_we = 1'b0;
        acc_v = 1'b0;
        acc_addr = addr_i;
        acc_data = wdata_i[15:0];
        n.rdata = '0;
        // Held write goes first once the command has ended
        if (r.pend_valid && !busy) begin
            acc_v = 1'b1;
            acc_addr = r.pend_addr;
            acc_data = r.pend_data;
            n.pend_valid = 1'b0;
        end
        if (we_i) begin
            unique case (addr_i)
                REG_CTRL: begin
                    if (!calib) begin
                        n.enable = wdata_i[CTRL_EN_BIT];
                    end
                    // Mode 3 is not a mode; switching mid-command is refused
                    if (!(new_mode inside {MODE_FACTORY, MODE_USER,
                            MODE_CALIB}) || busy) begin
                        ev[IRQ_REFUSED] = 1'b1;
                    end else if (new_mode != r.mode) begin
                        n.mode = new_mode;
                        if (new_mode != MODE_CALIB) begin
                            n.seq = SEQ_LOAD;
                            n.cnt = '0;
                            n.act_factory = (new_mode == MODE_FACTORY);
                        end
                    end
                end
                REG_IRQ_STAT: n.irq_stat = r.irq_stat & ~wdata_i[IRQ_W-1:0];
                REG_IRQ_MASK: n.irq_mask = wdata_i[IRQ_W-1:0];
                REG_COL, REG_GAIN, REG_OFFS: begin
                    if (!calib) begin
                        ev[IRQ_REFUSED] = 1'b1;
                    end else if (hold) begin
                        if (r.pend_valid) begin
                            ev[IRQ_REFUSED] = 1'b1;
                        end else begin
                            n.pend_valid = 1'b1;
                            n.pend_addr = addr_i;
                            n.pend_data = wdata_i[15:0];
                        end
                    end else begin
                        acc_v = 1'b1;
                    end
                end
                REG_CMD: begin
                    if (!calib || busy) begin
                        ev[IRQ_REFUSED] = 1'b1;
                    end else if (wdata_i[CMD_RELOAD_BIT]) begin
                        n.seq = SEQ_RELOAD;
                        n.cnt = '0;
                    end else if (wdata_i[CMD_STORE_BIT]) begin
                        n.seq = SEQ_STORE;
                        n.cnt = '0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Coefficient write from the host or from the held slot
        if (acc_v) begin
            if (acc_addr == REG_COL) begin
                n.col_idx = acc_data[COL_W-1:0];
            end else if (acc_addr == REG_GAIN) begin
                usr_we = 1'b1;
                usr_wd.gain = acc_data;
            end else if (acc_data[STEP_LOG-1:0] != '0) begin
                ev[IRQ_OFFS_ERR] = 1'b1;
            end else begin
                usr_we = 1'b1;
                usr_wd.offs = acc_data;
            end
        end
        if (re_i) begin
            unique case (addr_i)
                REG_CTRL: n.rdata = DATA_W'({r.mode, r.enable});
                REG_STATUS: n.rdata = DATA_W'({r.act_factory, r.pend_valid,
                    r.nv_valid, busy});
                REG_IRQ_STAT: n.rdata = DATA_W'(r.irq_stat);
                REG_IRQ_MASK: n.rdata = DATA_W'(r.irq_mask);
                REG_STEP: n.rdata = DATA_W'(OFFS_STEP);
                default: begin
                    if (coef_acc) begin
                        if (!calib || hold) begin
                            ev[IRQ_REFUSED] = 1'b1;
                        end else if (addr_i == REG_COL) begin
                            n.rdata = DATA_W'(r.col_idx);
                        end else if (addr_i == REG_GAIN) begin
                            n.rdata = DATA_W'(user_at_idx.gain);
                        end else begin
                            n.rdata = DATA_W'(user_at_idx.offs);
                        end
                    end
                end
            endcase
        end
        // Table walk, one column a cycle, no host action needed
        unique case (r.seq)
            SEQ_IDLE: begin
            end
            SEQ_LOAD: act_we = !r.act_factory;
            SEQ_RELOAD: begin
                usr_we = 1'b1;
                usr_wa = r.cnt;
                usr_wd = r.nv_valid ? nv_tbl[r.cnt] : COEF_NONE;
            end
            SEQ_STORE: nv_we = 1'b1;
        endcase
        if (busy) begin
            n.cnt = r.cnt + COL_W'(1);
            if (r.cnt == COL_LAST) begin
                n.seq = SEQ_IDLE;
                if (r.seq == SEQ_LOAD) begin
                    ev[IRQ_LOAD_DONE] = 1'b1;
                end else begin
                    ev[IRQ_CMD_DONE] = 1'b1;
                end
                if (r.seq == SEQ_STORE) begin
                    n.nv_valid = 1'b1;
                end
            end
        end
        // New events win over a same-cycle clear
        n.irq_stat = n.irq_stat | ev;
        // Stage one: column count and coefficient fetch
        n.s1_pix = pix_i;
        n.s1_en = corr_en;
        if (pix_i.valid) begin
            n.pix_col = cur_col + COL_W'(1);
        end
        if (r.act_factory) begin
            n.s1_coef = FACT_COEF[cam_gain_level_i];
        end else begin
            n.s1_coef = act_tbl[cur_col];
        end
    end

    // Table storage, no reset; saved copy stands for the backing store
    always_ff @(posedge ref_clk_i) begin
        if (usr_we) begin
            user_tbl[usr_wa] <= usr_wd;
        end
        if (nv_we) begin
            nv_tbl[r.cnt] <= user_tbl[r.cnt];
        end
        if (act_we) begin
            act_tbl[r.cnt] <= user_tbl[r.cnt];
        end
    end

    // Reset walks the user table to defaults before any use
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
            r.enable <= 1'b1;
            r.mode <= MODE_FACTORY;
            r.act_factory <= 1'b1;
            r.seq <= SEQ_RELOAD;
        end else begin
            r <= n;
        end
    end

    assign rdata_o = r.rdata;
    assign irq_o = |(r.irq_stat & r.irq_mask);

    cffc_apply u_apply (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .pix_i(r.s1_pix),
        .coef_i(r.s1_coef),
        .en_i(r.s1_en),
        .pix_o(pix_o)
    );

    sequence seq_load_start;
        we_i && addr_i == REG_CTRL && calib && !busy
            && new_mode == MODE_USER;
    endsequence
    sequence seq_load_run;
        (r.seq == SEQ_LOAD) ##255 (r.seq == SEQ_LOAD) ##1 (r.seq == SEQ_IDLE);
    endsequence

    AST_LOAD_ON_EXIT: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        seq_load_start |=> seq_load_run)
        else $error("table load missing or wrong length");
    AST_CALIB_OFF: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        calib |=> !r.s1_en)
        else $error("correction active in calibration");
    AST_REFUSE_MODE: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (we_i && addr_i == REG_GAIN && !calib) |=> r.irq_stat[IRQ_REFUSED])
        else $error("access outside calibration not refused");
    AST_OFFS_STEP: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (we_i && addr_i == REG_OFFS && calib && !hold
            && wdata_i[STEP_LOG-1:0] != '0) |=> r.irq_stat[IRQ_OFFS_ERR])
        else $error("bad offset not flagged");
    AST_COL_WRITE: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (we_i && addr_i == REG_COL && calib && !hold)
            |=> r.col_idx == $past(wdata_i[COL_W-1:0]))
        else $error("column index not taken");
    AST_HOLD_OFF: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (we_i && coef_acc && calib && busy && !r.pend_valid)
            |=> r.pend_valid ##[1:300] !r.pend_valid)
        else $error("held write not kept or never applied");
    AST_STORE_VALID: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (r.seq == SEQ_STORE && r.cnt == COL_LAST) |=> r.nv_valid && !busy)
        else $error("store did not mark saved table");
    AST_FACTORY_SRC: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        r.act_factory |=> r.s1_coef == $past(FACT_COEF[cam_gain_level_i]))
        else $error("factory coefficients not from gain level");
endmodule // cffc_top
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cffc_pkg::*;
;
    logic ref_clk;
    logic arst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic [LVL_W-1:0] lvl;
    cffc_pix_t pix_in;
    cffc_pix_t pix_out;
    int bad_count = 0;
    int tests_run = 0;
    logic [2:0] d1, d2, d3;
    logic [PIX_W-1:0] exp_q[$];
    cffc_coef_t k5 = '{gain: 16'h2000, offs: 16'hFFC0};

    cffc_top u_dut (
        .ref_clk_i(ref_clk), .arst_n_i(arst_n), .addr_i(addr),
        .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
        .irq_o(irq), .cam_gain_level_i(lvl), .pix_i(pix_in),
        .pix_o(pix_out)
    );
    cffc_pix_src src (.ref_clk_i(ref_clk), .pix_o(pix_in));

    // Free-running clock, 20 ns period
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Signed offset, u4.12 gain, clamped to the pixel range
    function automatic logic [15:0] corr(input logic [15:0] p,
                                         input cffc_coef_t c);
        longint v;
        v = (longint'(p) + longint'($signed(c.offs))) * longint'(c.gain);
        v = v >>> 12;
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        return v[15:0];
    endfunction

    // Sampled mid-cycle so the launching edge has settled
    always @(negedge ref_clk) begin
        if (!arst_n) begin
            d1 = '0;
            d2 = '0;
            d3 = '0;
        end else begin
            check({29'h0, pix_out.valid, pix_out.frame_start,
                   pix_out.line_start}, {29'h0, d3}, "beat timing");
            if (pix_out.valid === 1'b1 && exp_q.size() == 0)
                check(32'h1, 32'h0, "surplus beat");
            else if (pix_out.valid === 1'b1)
                check({16'h0, pix_out.data}, {16'h0, exp_q.pop_front()},
                      "pixel value");
            d3 = d2;
            d2 = d1;
            d1 = {pix_in.valid, pix_in.frame_start, pix_in.line_start};
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        we <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        re <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string w);
        logic [31:0] d;
        rd(a, d);
        check(d, e, w);
    endtask

    // Bounded poll; correction is off while busy, so streams wait for this
    task automatic wait_idle;
        logic [31:0] s;
        s = 32'h1;
        for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd(REG_STATUS, s);
        check(s & 32'h1, 32'h0, "busy stuck");
    endtask

    // Expected beats queued first, then one line from the sensor model
    task automatic stream(input logic [15:0] base, input cffc_coef_t k,
                          input cffc_coef_t kc5, input int gap);
        for (int c = 0; c < 8; c++)
            exp_q.push_back(corr(base + 16'(c), (c == 5) ? kc5 : k));
        src.send_line(base, gap);
        repeat (6) @(posedge ref_clk);
        check(32'(exp_q.size()), 32'h0, "beats missing");
    endtask

    task automatic t_reset;
        rd_chk(REG_CTRL, 32'h1, "ctrl reset");
        rd_chk(REG_STEP, {16'h0, OFFS_STEP}, "step");
        rd_chk(8'h40, 32'h0, "unmapped");
        wait_idle();
        rd_chk(REG_STATUS, 32'h8, "status reset");
        wr(REG_IRQ_STAT, 32'hF);
    endtask

    task automatic t_irq;
        wr(REG_GAIN, 32'h2000);
        rd_chk(REG_GAIN, 32'h0, "gain outside calib");
        check({31'h0, irq}, 32'h0, "irq masked");
        wr(REG_IRQ_MASK, 32'h1);
        check({31'h0, irq}, 32'h1, "irq raised");
        rd_chk(REG_IRQ_STAT, 32'h1, "refused flag");
        wr(REG_IRQ_STAT, 32'h1);
        check({31'h0, irq}, 32'h0, "irq cleared");
        wr(REG_CTRL, 32'h7);
        rd_chk(REG_CTRL, 32'h1, "mode 3 refused");
        rd_chk(REG_IRQ_STAT, 32'h1, "mode 3 flag");
        wr(REG_IRQ_STAT, 32'hF);
    endtask

    task automatic t_calib;
        wr(REG_CTRL, 32'h5);
        wait_idle();
        wr(REG_COL, 32'h5);
        wr(REG_GAIN, 32'h2000);
        wr(REG_OFFS, 32'hFFC0);
        wr(REG_OFFS, 32'h0041);
        rd_chk(REG_COL, 32'h5, "column");
        rd_chk(REG_GAIN, 32'h2000, "gain");
        rd_chk(REG_OFFS, 32'hFFC0, "offset kept");
        rd_chk(REG_IRQ_STAT, 32'h2, "step error");
        wr(REG_IRQ_STAT, 32'hF);
        wr(REG_CTRL, 32'h4);
        rd_chk(REG_CTRL, 32'h5, "enable locked");
        stream(16'h0100, COEF_NONE, COEF_NONE, 0);
    endtask

    task automatic t_table;
        logic [31:0] d;
        wr(REG_CMD, 32'h1);
        wr(REG_CMD, 32'h2);
        wr(REG_COL, 32'h7);
        // Only one write can wait; reads are refused while busy
        wr(REG_GAIN, 32'h1234);
        rd_chk(REG_GAIN, 32'h0, "read while busy");
        wait_idle();
        rd_chk(REG_COL, 32'h7, "held write");
        rd_chk(REG_GAIN, {16'h0, GAIN_UNITY},
               "second hold refused");
        rd_chk(REG_IRQ_STAT, 32'h5, "busy cmd flags");
        wr(REG_IRQ_STAT, 32'hF);
        wr(REG_COL, 32'h5);
        rd_chk(REG_GAIN, {16'h0, GAIN_UNITY}, "default gain");
        rd_chk(REG_OFFS, 32'h0, "default offset");
        wr(REG_GAIN, 32'h2000);
        wr(REG_OFFS, 32'hFFC0);
        wr(REG_CMD, 32'h2);
        wait_idle();
        rd(REG_STATUS, d);
        check(d & 32'h2, 32'h2, "saved flag");
        wr(REG_GAIN, 32'h1800);
        // Both command bits set: reload wins
        wr(REG_CMD, 32'h3);
        wait_idle();
        rd_chk(REG_GAIN, 32'h2000, "gain reloaded");
        rd_chk(REG_IRQ_STAT, 32'h4, "cmd done");
        wr(REG_IRQ_STAT, 32'hF);
    endtask

    task automatic t_user;
        // Sensor idle across the mode change
        wr(REG_CTRL, 32'h3);
        wait_idle();
        rd_chk(REG_IRQ_STAT, 32'h8, "load done");
        wr(REG_IRQ_STAT, 32'hF);
        stream(16'h0100, COEF_NONE, k5, 0);
        @(posedge ref_clk);
        lvl <= 2'h3;
        stream(16'h0100, COEF_NONE, k5, 2);
        wr(REG_CTRL, 32'h2);
        stream(16'h0100, COEF_NONE, COEF_NONE, 1);
    endtask

    task automatic t_factory;
        wr(REG_CTRL, 32'h1);
        wait_idle();
        wr(REG_IRQ_STAT, 32'hF);
        for (int l = 0; l < 4; l++) begin
            @(posedge ref_clk);
            lvl <= 2'(l);
            stream((l == 3) ? 16'hFFF0 : 16'h0100, FACT_COEF[l],
                   FACT_COEF[l], 0);
        end
    endtask

    // Watchdog sized well above the expected run length
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end

    // Main sequence; reset held for five clocks
    initial begin
        arst_n = 1'b0;
        addr = '0;
        wdata = '0;
        we = 1'b0;
        re = 1'b0;
        lvl = '0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_irq();
        t_calib();
        t_table();
        t_user();
        t_factory();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
